// ===== pkg/ptd_defs.svh
// Purpose: shared constants of the pci target decode pair
// Assumes: 25 MHz link clock
// Notes:   definitions only
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH

// configuration space offsets
`define PTD_CFG_CMD      8'h04
`define PTD_CFG_IOBASE   8'h10
`define PTD_CFG_MEMBASE  8'h14
`define PTD_CFG_ROMBASE  8'h30
// command register enables
`define PTD_CMD_IO_BIT   0
`define PTD_CMD_MEM_BIT  1
`define PTD_CMD_RESET    16'h0000
// rom base decode enable and io indicator
`define PTD_ROM_EN_BIT   0
`define PTD_IO_IND       8'h01
// general control register in the control window
`define PTD_CTL_GC       8'h0c
`define PTD_GC_PD_BIT    0
`define PTD_GC_SRST_BIT  1
`define PTD_FULL_BE      4'hf
// timing
`define PTD_CLK_NS       40
`define PTD_STROBE_NS    200
`define PTD_STROBE_CYC   ((`PTD_STROBE_NS + `PTD_CLK_NS - 1) / `PTD_CLK_NS)
`define PTD_SRST_CYC     15
// host command port offsets
`define PTD_H_ADDR       8'h00
`define PTD_H_WDATA      8'h04
`define PTD_H_CTRL       8'h08
`define PTD_H_STAT       8'h0c
`define PTD_H_RDATA      8'h10
// host ctrl and status bits
`define PTD_HC_GO        0
`define PTD_HC_SP_LO     1
`define PTD_HC_WR        3
`define PTD_HC_BE_LO     4
`define PTD_HS_BUSY      0
`define PTD_HS_RETRY     1
`define PTD_HS_ABORT     2
`define PTD_HS_INTA      3

`endif

// ===== pkg/ptd_pkg.sv
// Purpose: types of the pci target decode pair
// Assumes: nothing
// Notes:   constants live in ptd_defs.svh
package ptd_pkg;
	typedef enum logic [1:0] {sp_cfg, sp_io, sp_mem} ptd_space_t;
endpackage : ptd_pkg

// ===== pkg/ptd_link_if.sv
// Purpose: request and answer link between host and device
// Assumes: one clock, answers one cycle wide
// Notes:   request held until ack
`timescale 1ns/100ps
`default_nettype none
interface ptd_link_if;
	logic                 req;
	ptd_pkg::ptd_space_t  space;
	logic                 wr;
	logic [31:0]          addr;
	logic [3:0]           be;
	logic [31:0]          wdata;
	logic                 ack;
	logic                 retry;
	logic                 abort;
	logic [31:0]          rdata;
	logic                 inta;
	modport dev  (input req, space, wr, addr, be, wdata,
	              output ack, retry, abort, rdata, inta);
	modport host (output req, space, wr, addr, be, wdata,
	              input ack, retry, abort, rdata, inta);
endinterface : ptd_link_if
`default_nettype wire

// ===== logic/ptd_dev.sv
// Purpose: target decode, soft reset and flash window of the device
// Assumes: presetn is the hard reset pin; flash read data valid next cycle
// Notes:   control registers other than general control live elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defs.svh"

// Functional notes
// - soft reset returns state machines, pointers
// - soft reset only while power down clear
// - soft reset keeps configuration registers
// - fifteen clock reinit, host stays away
// - driver soft resets before bus mastering
// - 256 byte relocatable io window
// - 4 KB memory window, low 256 decode
// - 64 KB rom window, interrupt on inta
// - memory map enable latched at hard reset
// - io base 10h, memory base 14h
// - command enables gate decode, cleared reset
// - control registers dword access only
// - rom decodes with rom and memory enables
// - rom enable hides memory mapped control
// - rom reads return all four bytes
// - each enabled byte gets 200 ns strobe
// - access during flash write gets retry
// - rom decode disabled after reset
// - power down gates clock, limits access
// - hard reset reloads strap, enters power down
module ptd_dev #(
	parameter int STROBE_CYC = `PTD_STROBE_CYC,
	parameter int SRST_CYC   = `PTD_SRST_CYC
) (
	// clock and hard reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// link
	ptd_link_if.dev          lnk,
	// strap and interrupt source
	input  wire logic        ee_mem_map_en,
	input  wire logic        irq_req,
	// chip side controls
	output logic             soft_reset,
	output logic             sys_clk_en,
	// flash
	output logic [15:0]      fl_addr,
	output logic [7:0]       fl_wdata,
	output logic             fl_we,
	input  wire logic [31:0] fl_rdata
);
	generate
		if (STROBE_CYC < 1 || STROBE_CYC > 8 || SRST_CYC < 1 || SRST_CYC > 15)
			$error("ptd_dev: timing parameter out of range");
	endgenerate

	typedef enum {st_idle, st_romrd, st_flwr} ptd_dst_t;

	typedef struct packed {
		ptd_dst_t     st;
		logic         ack;
		logic         retry;
		logic         abort;
		logic [31:0]  rdata;
		logic         inta;
		logic [15:0]  cmd;
		logic [23:0]  io_base;
		logic [19:0]  mem_base;
		logic [15:0]  rom_base;
		logic         rom_en;
		logic         pd;
		logic         mm_en;
		logic         mm_loaded;
		logic [3:0]   srst_cnt;
		logic [15:0]  fl_addr;
		logic [7:0]   fl_wdata;
		logic         fl_we;
		logic [3:0]   fl_mask;
		logic [31:0]  fl_buf;
		logic [2:0]   fl_cnt;
	} ptd_dstate_t;

	ptd_dstate_t s_ff;
	ptd_dstate_t nxt_s;

	function automatic logic [31:0] merge(input logic [31:0] o,
	                                      input logic [31:0] w,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = w[8*i +: 8];
		end
		return r;
	endfunction : merge

	logic        take;
	logic        mem_on;
	logic        io_hit;
	logic        ctl_hit;
	logic        rom_hit;
	logic [1:0]  idx;
	logic [31:0] w32;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.ack = 1'b0;
		nxt_s.retry = 1'b0;
		nxt_s.abort = 1'b0;
		nxt_s.inta = irq_req;
		take = lnk.req && !s_ff.ack;
		mem_on = s_ff.cmd[`PTD_CMD_MEM_BIT];
		io_hit = lnk.space == ptd_pkg::sp_io && s_ff.cmd[`PTD_CMD_IO_BIT]
		         && lnk.addr[31:8] == s_ff.io_base;
		// memory control gated by rom enable
		// only the low 256 bytes decode
		ctl_hit = io_hit || (lnk.space == ptd_pkg::sp_mem && mem_on
		          && s_ff.mm_en && !s_ff.rom_en
		          && lnk.addr[31:12] == s_ff.mem_base
		          && lnk.addr[11:8] == 4'h0);
		rom_hit = lnk.space == ptd_pkg::sp_mem && mem_on && s_ff.rom_en
		          && lnk.addr[31:16] == s_ff.rom_base;
		idx = 2'd3;
		for (int i = 3; i >= 0; i--) begin
			if (s_ff.fl_mask[i])
				idx = 2'(i);
		end
		w32 = 32'h0;

		// strap taken once after hard reset
		if (!s_ff.mm_loaded) begin
			nxt_s.mm_en = ee_mem_map_en;
			nxt_s.mm_loaded = 1'b1;
		end
		if (s_ff.srst_cnt != 4'h0)
			nxt_s.srst_cnt = s_ff.srst_cnt - 4'h1;

		case (s_ff.st)
			st_idle: begin
				if (take) begin
					nxt_s.ack = 1'b1;
					nxt_s.rdata = 32'h0;
					if (s_ff.srst_cnt != 4'h0) begin
						nxt_s.retry = 1'b1;
					end else if (lnk.space == ptd_pkg::sp_cfg) begin
						if (lnk.addr[7:0] == `PTD_CFG_CMD) begin
							w32 = merge({16'h0, s_ff.cmd}, lnk.wdata, lnk.be);
							nxt_s.rdata = {16'h0, s_ff.cmd};
							if (lnk.wr)
								nxt_s.cmd = w32[15:0];
						end else if (lnk.addr[7:0] == `PTD_CFG_IOBASE) begin
							w32 = merge({s_ff.io_base, 8'h0}, lnk.wdata, lnk.be);
							nxt_s.rdata = {s_ff.io_base, `PTD_IO_IND};
							if (lnk.wr)
								nxt_s.io_base = w32[31:8];
						end else if (lnk.addr[7:0] == `PTD_CFG_MEMBASE) begin
							w32 = merge({s_ff.mem_base, 12'h0}, lnk.wdata, lnk.be);
							nxt_s.rdata = {s_ff.mem_base, 12'h0};
							if (lnk.wr)
								nxt_s.mem_base = w32[31:12];
						end else if (lnk.addr[7:0] == `PTD_CFG_ROMBASE) begin
							w32 = merge({s_ff.rom_base, 15'h0, s_ff.rom_en},
							            lnk.wdata, lnk.be);
							nxt_s.rdata = {s_ff.rom_base, 15'h0, s_ff.rom_en};
							if (lnk.wr) begin
								nxt_s.rom_base = w32[31:16];
								nxt_s.rom_en = w32[`PTD_ROM_EN_BIT];
							end
						end
					end else if (ctl_hit) begin
						// only general control while powered down
						if (lnk.be == `PTD_FULL_BE
						    && lnk.addr[7:0] == `PTD_CTL_GC) begin
							nxt_s.rdata[`PTD_GC_PD_BIT] = s_ff.pd;
							if (lnk.wr) begin
								nxt_s.pd = lnk.wdata[`PTD_GC_PD_BIT];
								if (lnk.wdata[`PTD_GC_SRST_BIT] && !s_ff.pd) begin
									nxt_s.pd = 1'b0;
									nxt_s.srst_cnt = 4'(SRST_CYC);
									nxt_s.fl_mask = 4'h0;
									nxt_s.fl_we = 1'b0;
								end
							end
						end
					end else if (rom_hit) begin
						if (!s_ff.pd) begin
							nxt_s.fl_addr = {lnk.addr[15:2], 2'b00};
							if (lnk.wr) begin
								nxt_s.fl_mask = lnk.be;
								nxt_s.fl_buf = lnk.wdata;
								nxt_s.fl_cnt = 3'h0;
								nxt_s.st = st_flwr;
							end else begin
								nxt_s.ack = 1'b0;
								nxt_s.st = st_romrd;
							end
						end
					end else begin
						nxt_s.abort = 1'b1;
					end
				end
			end
			st_romrd: begin
				nxt_s.rdata = fl_rdata;
				nxt_s.ack = 1'b1;
				nxt_s.st = st_idle;
			end
			st_flwr: begin
				// retry while a byte is being written
				if (take) begin
					nxt_s.ack = 1'b1;
					nxt_s.retry = 1'b1;
				end
				if (s_ff.fl_mask == 4'h0) begin
					nxt_s.st = st_idle;
				end else if (!s_ff.fl_we) begin
					nxt_s.fl_we = 1'b1;
					nxt_s.fl_cnt = 3'(STROBE_CYC - 1);
					nxt_s.fl_addr[1:0] = idx;
					nxt_s.fl_wdata = 8'(s_ff.fl_buf >> {idx, 3'b000});
				end else if (s_ff.fl_cnt != 3'h0) begin
					// strobe held for its full width
					nxt_s.fl_cnt = s_ff.fl_cnt - 3'h1;
				end else begin
					nxt_s.fl_we = 1'b0;
					nxt_s.fl_mask[idx] = 1'b0;
				end
			end
			default: nxt_s.st = st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.st <= st_idle;
			s_ff.cmd <= `PTD_CMD_RESET;
			s_ff.rom_en <= 1'b0;
			s_ff.pd <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lnk.ack    = s_ff.ack;
	assign lnk.retry  = s_ff.retry;
	assign lnk.abort  = s_ff.abort;
	assign lnk.rdata  = s_ff.rdata;
	assign lnk.inta   = s_ff.inta;
	assign soft_reset = s_ff.srst_cnt != 4'h0;
	// system clock gated in power down
	assign sys_clk_en = !s_ff.pd;
	assign fl_addr    = s_ff.fl_addr;
	assign fl_wdata   = s_ff.fl_wdata;
	assign fl_we      = s_ff.fl_we;
endmodule : ptd_dev
`default_nettype wire

// ===== logic/ptd_host.sv
// Purpose: host end issuing link requests ordered over apb
// Assumes: software polls busy before the next go
// Notes:   one request in flight, no automatic retry
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defs.svh"
module ptd_host #(
	parameter int SRST_CYC = `PTD_SRST_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	ptd_link_if.host         lnk
);
	generate
		if (SRST_CYC < 1 || SRST_CYC > 15)
			$error("ptd_host: SRST_CYC out of range");
	endgenerate

	typedef enum {hs_idle, hs_hold, hs_req} ptd_hst_t;

	typedef struct packed {
		ptd_hst_t             st;
		logic [31:0]          addr;
		logic [31:0]          wdata;
		ptd_pkg::ptd_space_t  space;
		logic                 wr;
		logic [3:0]           be;
		logic                 req;
		logic                 retry;
		logic                 abort;
		logic [31:0]          rdata;
		logic [31:0]          prdata;
		logic [3:0]           hold;
	} ptd_hstate_t;

	ptd_hstate_t s_ff;
	ptd_hstate_t nxt_s;
	logic        mapped;
	logic        go;

	always_comb begin
		nxt_s = s_ff;
		mapped = paddr == `PTD_H_ADDR || paddr == `PTD_H_WDATA
		         || paddr == `PTD_H_CTRL || paddr == `PTD_H_STAT
		         || paddr == `PTD_H_RDATA;
		go = 1'b0;
		if (s_ff.hold != 4'h0)
			nxt_s.hold = s_ff.hold - 4'h1;
		// read data staged in the setup cycle
		if (psel && !penable) begin
			nxt_s.prdata = 32'h0;
			if (paddr == `PTD_H_ADDR)
				nxt_s.prdata = s_ff.addr;
			else if (paddr == `PTD_H_WDATA)
				nxt_s.prdata = s_ff.wdata;
			else if (paddr == `PTD_H_CTRL)
				nxt_s.prdata = {24'h0, s_ff.be, s_ff.wr, s_ff.space, 1'b0};
			else if (paddr == `PTD_H_STAT)
				nxt_s.prdata = {28'h0, lnk.inta, s_ff.abort, s_ff.retry,
				                s_ff.st != hs_idle};
			else if (paddr == `PTD_H_RDATA)
				nxt_s.prdata = s_ff.rdata;
		end
		// orders ignored while busy
		if (psel && penable && pwrite && s_ff.st == hs_idle) begin
			if (paddr == `PTD_H_ADDR) begin
				nxt_s.addr = pwdata;
			end else if (paddr == `PTD_H_WDATA) begin
				nxt_s.wdata = pwdata;
			end else if (paddr == `PTD_H_CTRL) begin
				nxt_s.space = ptd_pkg::ptd_space_t'(pwdata[`PTD_HC_SP_LO +: 2]);
				nxt_s.wr = pwdata[`PTD_HC_WR];
				nxt_s.be = pwdata[`PTD_HC_BE_LO +: 4];
				// io control accesses always whole dwords
				if (ptd_pkg::ptd_space_t'(pwdata[`PTD_HC_SP_LO +: 2])
				    == ptd_pkg::sp_io)
					nxt_s.be = `PTD_FULL_BE;
				go = pwdata[`PTD_HC_GO];
			end
		end
		case (s_ff.st)
			hs_idle: begin
				if (go) begin
					nxt_s.retry = 1'b0;
					nxt_s.abort = 1'b0;
					nxt_s.st = hs_hold;
				end
			end
			hs_hold: begin
				if (s_ff.hold == 4'h0) begin
					nxt_s.req = 1'b1;
					nxt_s.st = hs_req;
				end
			end
			hs_req: begin
				if (lnk.ack) begin
					nxt_s.req = 1'b0;
					nxt_s.retry = lnk.retry;
					nxt_s.abort = lnk.abort;
					nxt_s.rdata = lnk.rdata;
					nxt_s.st = hs_idle;
					// soft reset starts the quiet time
					if (!lnk.retry && !lnk.abort && s_ff.wr
					    && s_ff.space != ptd_pkg::sp_cfg
					    && s_ff.addr[7:0] == `PTD_CTL_GC
					    && s_ff.wdata[`PTD_GC_SRST_BIT])
						nxt_s.hold = 4'(SRST_CYC);
				end
			end
			default: nxt_s.st = hs_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.st <= hs_idle;
			s_ff.space <= ptd_pkg::sp_cfg;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata    = s_ff.prdata;
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign lnk.req   = s_ff.req;
	assign lnk.space = s_ff.space;
	assign lnk.wr    = s_ff.wr;
	assign lnk.addr  = s_ff.addr;
	assign lnk.be    = s_ff.be;
	assign lnk.wdata = s_ff.wdata;
endmodule : ptd_host
`default_nettype wire

// ===== test/ptd_monitor.sv
// Purpose: link, soft reset and flash strobe checks
// Assumes: one clock, asynchronous active low reset
// Notes:   counters replace long repetitions
`timescale 1ns/100ps
`default_nettype none
module ptd_monitor #(
	parameter int STROBE_CYC = 5,
	parameter int SRST_CYC   = 15
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// link
	input wire logic        req,
	input wire logic        ack,
	input wire logic        retry,
	input wire logic        abort,
	input wire logic [31:0] rdata,
	input wire logic        inta,
	// device side
	input wire logic        irq_req,
	input wire logic        soft_reset,
	input wire logic        fl_we
);
	logic [7:0] srst_len_ff;
	logic [7:0] we_len_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// run lengths of the two long levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srst_len_ff <= 8'h00;
			we_len_ff   <= 8'h00;
		end else begin
			srst_len_ff <= soft_reset ? srst_len_ff + 8'h01 : 8'h00;
			we_len_ff   <= fl_we ? we_len_ff + 8'h01 : 8'h00;
		end
	end
	sequence s_answer;
		req && ack;
	endsequence
	sequence s_released;
		!req && !ack;
	endsequence
	chk_ack_release: assert property (s_answer |=> s_released)
		else $error("ack or request held past answer");
	chk_ack_req: assert property (ack |-> req)
		else $error("ack without request");
	chk_retry_ack: assert property (retry |-> ack)
		else $error("retry without ack");
	chk_abort_empty: assert property (
		abort |-> ack && rdata == 32'h0)
		else $error("abort with data");
	chk_inta_copy: assert property (
		$past(presetn) |-> inta == $past(irq_req))
		else $error("interrupt not following source");
	chk_srst_length: assert property (
		$fell(soft_reset) |-> srst_len_ff == 8'(SRST_CYC))
		else $error("soft reset length wrong");
	chk_srst_retry: assert property (
		soft_reset && $past(soft_reset) && ack |-> retry)
		else $error("access accepted during soft reset");
	chk_flash_retry: assert property (fl_we && ack |-> retry)
		else $error("access accepted during flash write");
	chk_strobe_length: assert property (
		$fell(fl_we) |-> we_len_ff == 8'(STROBE_CYC))
		else $error("flash strobe length wrong");
endmodule : ptd_monitor
`default_nettype wire

// ===== test/tb_pci_target_decode_soft_reset.sv
// Purpose: end to end test of host and device over the link
// Assumes: flash modelled from its address
// Notes:   host waits out soft reset itself, so no retry there
`timescale 1ns/100ps
`default_nettype none
`include "ptd_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_pci_target_decode_soft_reset;
	localparam logic [1:0] sc = 2'(ptd_pkg::sp_cfg);
	localparam logic [1:0] si = 2'(ptd_pkg::sp_io);
	localparam logic [1:0] sm = 2'(ptd_pkg::sp_mem);
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ee_mem_map_en;
	logic        irq_req;
	logic        soft_reset;
	logic        sys_clk_en;
	logic [15:0] fl_addr;
	logic [7:0]  fl_wdata;
	logic        fl_we;
	logic [31:0] fl_rdata;
	logic [31:0] rd;
	logic [31:0] st;
	logic        slv;
	logic        srst_d = 1'b0;
	logic        we_d = 1'b0;
	logic [23:0] fl_log[$];
	logic [23:0] fl_exp[$];
	int          err_total;
	int          cmp_count;
	int          cyc = 0;
	int          srst_seen = 0;
	logic [31:0] bar_off[3] = '{32'h10, 32'h14, 32'h30};
	logic [31:0] bar_exp[3] = '{32'hffffff01, 32'hfffff000, 32'hffff0000};
	assign fl_rdata = {2'h0, fl_addr[15:2], 16'hc3a5};
	ptd_link_if lnk ();
	ptd_host u_ptd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
	ptd_dev u_ptd_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk),
		.ee_mem_map_en(ee_mem_map_en), .irq_req(irq_req),
		.soft_reset(soft_reset), .sys_clk_en(sys_clk_en), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_we(fl_we), .fl_rdata(fl_rdata));
	ptd_monitor #(.STROBE_CYC(`PTD_STROBE_CYC), .SRST_CYC(`PTD_SRST_CYC))
		u_ptd_monitor (.pclk(pclk), .presetn(presetn),
		.req(lnk.req), .ack(lnk.ack), .retry(lnk.retry), .abort(lnk.abort),
		.rdata(lnk.rdata), .inta(lnk.inta), .irq_req(irq_req),
		.soft_reset(soft_reset), .fl_we(fl_we));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic final_report();
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// soft reset starts, strobe starts and hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		srst_d <= soft_reset;
		we_d <= fl_we;
		if (soft_reset && !srst_d)
			srst_seen <= srst_seen + 1;
		if (fl_we && !we_d)
			fl_log.push_back({fl_addr, fl_wdata});
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one link transfer; st keeps the final status
	task automatic lk(input logic [1:0] sp, input logic w,
		input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		apb(1'b1, `PTD_H_ADDR, a);
		apb(1'b1, `PTD_H_WDATA, d);
		apb(1'b1, `PTD_H_CTRL, {24'h0, be, w, sp, 1'b1});
		// a hung poll is ended by the bench timeout only
		do
			apb(1'b0, `PTD_H_STAT, 32'h0);
		while (rd[`PTD_HS_BUSY] !== 1'b0);
		st = rd;
		apb(1'b0, `PTD_H_RDATA, 32'h0);
	endtask : lk
	task automatic fw(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] be);
		for (int k = 0; k < 4; k++)
			if (be[k])
				fl_exp.push_back({a[15:2], 2'(k), d[8*k +: 8]});
		lk(sm, 1'b1, a, d, be);
	endtask : fw
	initial begin
		{presetn, psel, penable, pwrite, irq_req} = 5'h00;
		{paddr, pwdata} = 40'h0;
		{err_total, cmp_count} = {2{32'h0}};
		ee_mem_map_en = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		lk(sc, 1'b0, 32'h04, 32'h0, 4'hf);
		`CHK(rd[1:0], 2'b00)
		for (int i = 0; i < 3; i++) begin
			lk(sc, 1'b1, bar_off[i], 32'hfffffffe, 4'hf);
			lk(sc, 1'b0, bar_off[i], 32'h0, 4'hf);
			`CHK(rd, bar_exp[i])
		end
		lk(sc, 1'b1, 32'h10, 32'h1000, 4'hf);
		lk(sc, 1'b1, 32'h14, 32'h20000, 4'hf);
		lk(si, 1'b0, 32'h100c, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_ABORT], 1'b1)
		lk(sc, 1'b1, 32'h04, 32'h3, 4'hf);
		lk(si, 1'b1, 32'h100c, 32'h3, 4'hf);
		`CHK(srst_seen, 0)
		lk(sm, 1'b1, 32'h2000c, 32'h0, 4'h1);
		`CHK(sys_clk_en, 1'b0)
		lk(si, 1'b1, 32'h100c, 32'h0, 4'hf);
		`CHK(sys_clk_en, 1'b1)
		lk(sm, 1'b0, 32'h2000c, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_ABORT], 1'b0)
		ee_mem_map_en <= 1'b0;
		lk(sm, 1'b0, 32'h2000c, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_ABORT], 1'b0)
		lk(sm, 1'b1, 32'h2000c, 32'h2, 4'hf);
		`CHK(srst_seen, 1)
		lk(sc, 1'b0, 32'h10, 32'h0, 4'hf);
		`CHK(rd, 32'h1001)
		lk(sc, 1'b1, 32'h30, 32'h00800001, 4'hf);
		lk(sm, 1'b0, 32'h2000c, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_ABORT], 1'b1)
		lk(sm, 1'b0, 32'h00800008, 32'h0, 4'h1);
		`CHK(rd, 32'h0002c3a5)
		fw(32'h00800010, 32'h44332211, 4'h5);
		repeat (20) @(posedge pclk);
		fw(32'h00800014, 32'h88776655, 4'hf);
		lk(sc, 1'b0, 32'h04, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_RETRY], 1'b1)
		repeat (40) @(posedge pclk);
		lk(sc, 1'b0, 32'h04, 32'h0, 4'hf);
		`CHK(rd[1:0], 2'b11)
		`CHK(fl_log.size(), fl_exp.size())
		foreach (fl_exp[k])
			`CHK(fl_log[k], fl_exp[k])
		irq_req <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, `PTD_H_STAT, 32'h0);
		`CHK(rd[`PTD_HS_INTA], 1'b1)
		apb(1'b0, 8'h20, 32'h0);
		`CHK(slv, 1'b1)
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		lk(sc, 1'b0, 32'h30, 32'h0, 4'hf);
		`CHK(rd[0], 1'b0)
		lk(sc, 1'b1, 32'h14, 32'h20000, 4'hf);
		lk(sc, 1'b1, 32'h04, 32'h2, 4'hf);
		lk(sm, 1'b0, 32'h2000c, 32'h0, 4'hf);
		`CHK(st[`PTD_HS_ABORT], 1'b1)
		final_report();
	end
endmodule : tb_pci_target_decode_soft_reset
`default_nettype wire
